// file: rocl_map.svh
`ifndef ROCL_MAP_SVH
`define ROCL_MAP_SVH
// ****************************************
// counting and timing constants
// ****************************************
`define ROCL_CNT_W 4
`define ROCL_ARM_CYCLES 4'h4
`define ROCL_LAST_CYCLE 4'h8
`define ROCL_MASK_PCT 75
`define ROCL_DECISION_US 80
`define ROCL_CLK_MHZ 125
`define ROCL_DECISION_CLKS (`ROCL_DECISION_US * `ROCL_CLK_MHZ)
`endif

// file: rocl_pkg.sv
package rocl_pkg;
  typedef enum logic [1:0] {
    ROCL_IDLE,
    ROCL_COUNT,
    ROCL_WATCH,
    ROCL_FAULT
  } rocl_state_e;
endpackage

// file: rocl_edge.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// rising edge detector for synchronous strobes
// ****************************************
module rocl_edge (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic level_in,
  output logic rise
);
  logic last_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= level_in;
    end
  end
  assign rise = level_in & ~last_ff;
endmodule
`default_nettype wire

// file: rocl_latch.sv
`timescale 1ns/100ps
`default_nettype none
`include "rocl_map.svh"
// Operation
// - the sense comparator is ignored while the ramp is inside the charge-phase mask window (about 75% of swing).
// - an over-current event is registered only when the sense stays high beyond the mask window in an on period.
// - the first event starts a counter that advances once per ramp oscillator cycle.
// - a further event once four cycles are counted forces the drive off in a latched fault.
// - with no event from the end of cycle four through cycle eight the counter clears and the drive keeps running.
// - the fault holds until a main supply power-on reset, the only release.
// - at the lower nominal ramp rate the decision takes about 80 us, i.e. eight counted cycles.
module rocl_latch (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ramp_cycle_start,
  input wire logic ramp_mask_window,
  input wire logic switch_on,
  input wire logic overcurrent_sense_input,
  output logic switch_drive_output,
  output logic fault_latched,
  output logic event_pulse,
  output logic [`ROCL_CNT_W-1:0] cycle_count
);
  // ****************************************
  // ramp cycle edge
  // ****************************************
  // arst_n is the power-on reset of the main supply; nothing else clears the fault
  logic cyc_rise;

  rocl_edge u_cyc (
    .clk(clk),
    .arst_n(arst_n),
    .level_in(ramp_cycle_start),
    .rise(cyc_rise)
  );

  // ****************************************
  // event qualification
  // ****************************************
  logic qual;
  logic seen_ff;
  logic event_ff;

  // sense during the mask is switching noise, so only sense after it counts
  assign qual = overcurrent_sense_input & switch_on & ~ramp_mask_window;

  // one event per ramp cycle at most; the cycle edge clears before a new sense sets
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_ff <= 1'b0;
    end else if (cyc_rise) begin
      seen_ff <= 1'b0;
    end else if (qual) begin
      seen_ff <= 1'b1;
    end
  end
  // a sense that meets the cycle edge is dropped, it belongs to neither cycle cleanly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_ff <= 1'b0;
    end else begin
      event_ff <= qual & ~seen_ff & ~cyc_rise;
    end
  end

  assign event_pulse = event_ff;

  // ****************************************
  // latch sequencer
  // ****************************************
  rocl_pkg::rocl_state_e state_ff;
  logic [`ROCL_CNT_W-1:0] cnt_ff;
  logic watch_hit;

  assign watch_hit = (state_ff == rocl_pkg::ROCL_WATCH) && event_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= rocl_pkg::ROCL_IDLE;
    end else begin
      unique case (state_ff)
        rocl_pkg::ROCL_IDLE: begin
          if (event_ff) begin
            state_ff <= rocl_pkg::ROCL_COUNT;
          end
        end
        rocl_pkg::ROCL_COUNT: begin
          // events here are ignored on purpose
          if (cyc_rise && (cnt_ff + 4'h1 == `ROCL_ARM_CYCLES)) begin
            state_ff <= rocl_pkg::ROCL_WATCH;
          end
        end
        rocl_pkg::ROCL_WATCH: begin
          if (event_ff) begin
            state_ff <= rocl_pkg::ROCL_FAULT;
          end else if (cyc_rise && (cnt_ff + 4'h1 == `ROCL_LAST_CYCLE)) begin
            state_ff <= rocl_pkg::ROCL_IDLE;
          end
        end
        rocl_pkg::ROCL_FAULT: begin
          state_ff <= rocl_pkg::ROCL_FAULT;
        end
      endcase
    end
  end

  // ****************************************
  // ramp cycle counter
  // ****************************************
  // steps on ramp edges only, so events can neither restart nor stretch the count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        rocl_pkg::ROCL_IDLE: begin
          cnt_ff <= '0;
        end
        rocl_pkg::ROCL_COUNT: begin
          if (cyc_rise) begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        rocl_pkg::ROCL_WATCH: begin
          if (event_ff) begin
            cnt_ff <= cnt_ff;
          end else if (cyc_rise) begin
            if (cnt_ff + 4'h1 == `ROCL_LAST_CYCLE) begin
              cnt_ff <= '0;
            end else begin
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        rocl_pkg::ROCL_FAULT: begin
          cnt_ff <= cnt_ff;
        end
      endcase
    end
  end

  assign cycle_count = cnt_ff;

  // ****************************************
  // fault flag
  // ****************************************
  // no clear term on purpose: the user must cycle the main supply to restart
  logic fault_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_ff <= 1'b0;
    end else if (watch_hit) begin
      fault_ff <= 1'b1;
    end
  end

  assign fault_latched = fault_ff;

  // ****************************************
  // drive gating
  // ****************************************
  // gating on the event itself saves a cycle of drive before the flag settles
  logic drive_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= switch_on & ~fault_ff & ~watch_hit;
    end
  end

  assign switch_drive_output = drive_ff;

  // ****************************************
  // check helper: ramp edges since first event
  // ****************************************
  logic [`ROCL_CNT_W-1:0] edges_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edges_ff <= '0;
    end else if (state_ff == rocl_pkg::ROCL_IDLE) begin
      edges_ff <= '0;
    end else if (cyc_rise && state_ff != rocl_pkg::ROCL_FAULT) begin
      edges_ff <= edges_ff + 4'h1;
    end
  end

  // ****************************************
  // checks: qualification
  // ****************************************
  a_mask_blocks_event: assert property (
    @(posedge clk) disable iff (!arst_n) ramp_mask_window |=> !event_ff)
    else $error("event raised inside mask");
  a_event_needs_sense: assert property (
    @(posedge clk) disable iff (!arst_n) event_ff |-> $past(overcurrent_sense_input) && $past(switch_on))
    else $error("event without sense");
  a_one_event_cycle: assert property (
    @(posedge clk) disable iff (!arst_n) event_ff |=> !event_ff)
    else $error("event longer than one clock");
  a_edge_drops_event: assert property (
    @(posedge clk) disable iff (!arst_n) cyc_rise |=> !event_ff)
    else $error("event on a cycle edge");

  // ****************************************
  // checks: counting
  // ****************************************
  a_first_event_arms: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_ff == rocl_pkg::ROCL_IDLE && event_ff |=> state_ff == rocl_pkg::ROCL_COUNT && cnt_ff == 4'h0)
    else $error("counter not started");
  a_count_steps: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_ff == rocl_pkg::ROCL_COUNT && cyc_rise |=> cnt_ff == $past(cnt_ff) + 4'h1)
    else $error("count did not step");
  a_no_restart: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_ff == rocl_pkg::ROCL_COUNT && !cyc_rise |=> cnt_ff == $past(cnt_ff))
    else $error("count disturbed");
  a_arm_at_four: assert property (
    @(posedge clk) disable iff (!arst_n) $rose(state_ff == rocl_pkg::ROCL_WATCH) |-> cnt_ff == 4'h4)
    else $error("watch not at four");
  a_decision_window: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(fault_ff) |-> edges_ff >= `ROCL_ARM_CYCLES && edges_ff <= `ROCL_LAST_CYCLE)
    else $error("fault outside watch span");
  a_idle_count_zero: assert property (
    @(posedge clk) disable iff (!arst_n) state_ff == rocl_pkg::ROCL_IDLE |-> cnt_ff == 4'h0)
    else $error("count left in idle");
  a_quiet_clears: assert property (
    @(posedge clk) disable iff (!arst_n)
    state_ff == rocl_pkg::ROCL_WATCH && !event_ff && cyc_rise && cnt_ff == 4'h7 |=>
    state_ff == rocl_pkg::ROCL_IDLE && cnt_ff == 4'h0)
    else $error("counter not cleared");
  a_count_bounded: assert property (
    @(posedge clk) disable iff (!arst_n) cnt_ff < `ROCL_LAST_CYCLE)
    else $error("count beyond last cycle");

  // ****************************************
  // checks: latch and drive
  // ****************************************
  a_fault_drive_off: assert property (
    @(posedge clk) disable iff (!arst_n) watch_hit |=> fault_latched ##1 !switch_drive_output)
    else $error("fault not latched");
  a_fault_from_watch: assert property (
    @(posedge clk) disable iff (!arst_n) $rose(fault_ff) |-> $past(watch_hit))
    else $error("fault without watch event");
  a_fault_holds: assert property (
    @(posedge clk) disable iff (!arst_n) fault_latched |=> fault_latched && !switch_drive_output)
    else $error("fault released");
  a_drive_follows: assert property (
    @(posedge clk) disable iff (!arst_n) !fault_ff && !watch_hit |=> switch_drive_output == $past(switch_on))
    else $error("drive not following switch demand");
endmodule
`default_nettype wire

// file: rocl_sw_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// external switch and sense resistor
// ****************************************
module rocl_sw_model (
  input wire logic drive,
  input wire logic overload,
  output logic sense
);
  // no current flows with the switch off, so a drive stuck low can never trip
  assign sense = drive & overload;
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rocl_map.svh"
// ****************************************
// over-current latch bench
// ****************************************
module tb_top;
  logic clk = 0, arst_n = 0, rs = 0, mk = 0, son = 1, ovl = 0, sense, drv, flt, evp;
  logic [3:0] cnt;
  int fail_count = 0, compares = 0, tmo = 0, evs = 0;
  always #4 clk = ~clk;
  rocl_latch i_dut (.clk(clk), .arst_n(arst_n), .ramp_cycle_start(rs), .ramp_mask_window(mk),
    .switch_on(son), .overcurrent_sense_input(sense), .switch_drive_output(drv),
    .fault_latched(flt), .event_pulse(evp), .cycle_count(cnt));
  rocl_sw_model i_sw (.drive(drv), .overload(ovl), .sense(sense));
  always @(posedge clk) begin
    tmo++;
    if (evp === 1'b1) evs++;
    if (tmo == 2000) begin
      fail_count++;
      finish_test();
    end
  end
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // first event, three ignored while counting, and one in the watch span unless clean
  function automatic logic [3:0] exp_events(input int k);
    return (k < 4) ? 4'h5 : 4'h4;
  endfunction
  // one ramp cycle of 16 clocks; mask covers 12 of them (75%)
  // m=1 overload inside mask only, m=2 overload after mask, m=3 as 2 with switch off
  task cyc(input int m);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      rs <= (i < 2);
      mk <= (i < (16 * `ROCL_MASK_PCT) / 100);
      son <= !(m == 3 && i >= 12);
      ovl <= (m == 1) ? (i < 11) : (m >= 2 && i >= 12);
    end
  endtask
  task finish_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    int k;
    void'($urandom(27130));
    repeat (5) @(posedge clk);
    arst_n <= 1;
    repeat (3) cyc(1);
    cyc(3);
    chk(evs[3:0], 4'h0);
    chk(cnt, 4'h0);
    $display("mask test done");
    for (int t = 0; t < 5; t++) begin
      // corners: watch event first and last cycle, and a clean run
      k = (t == 0) ? 0 : (t == 1) ? 3 : (t == 2) ? 4 : $urandom_range(3, 0);
      evs = 0;
      cyc(2);
      chk(evs[3:0], 4'h1);
      // events in cycles 1..3 must not restart the count
      for (int c = 1; c < 9; c++) begin
        cyc((c < 4 || (c == 4 + k && k < 4)) ? 2 : 0);
        if (c == 3) chk(cnt, 4'h3);
      end
      chk(evs[3:0], exp_events(k));
      if (k < 4) begin
        chk({3'h0, flt}, 4'h1);
        chk({3'h0, drv}, 4'h0);
        arst_n <= 0;
        @(posedge clk);
        arst_n <= 1;
        cyc(0);
        chk({3'h0, flt}, 4'h0);
        chk({3'h0, drv}, 4'h1);
      end else begin
        chk(cnt, 4'h0);
        chk({3'h0, flt}, 4'h0);
        chk({3'h0, drv}, 4'h1);
      end
      $display("latch test %0d done", t);
    end
    finish_test();
  end
endmodule
`default_nettype wire
